// ---- hdl/ivofh_delay_timer.sv ----
// Delay timer: 2^code time units, one unit being unit_ticks clock cycles.
// Assumes unit_ticks is held steady while a delay runs.
module ivofh_delay_timer #(
    parameter int UNIT_W = 16
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic start,
    input wire logic [2:0] code,
    input wire logic [UNIT_W-1:0] unit_ticks,
    output logic done
);
    import ivofh_pkg::*;

    typedef struct packed {
        logic running;
        logic done;
        logic [UNIT_W-1:0] pre;
        logic [7:0] units;
    } ivofh_tmr_state_type;

    ivofh_tmr_state_type s_r, s_nxt;

    // A start reloads at once, so a new attempt always gets a full delay
    always_comb begin
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        if (start) begin
            s_nxt.running = 1'b1;
            s_nxt.pre = '0;
            s_nxt.units = 8'h01 << code;
        end else if (s_r.running) begin
            // Zero ticks per unit is treated as one tick
            if (s_r.pre + UNIT_W'(1) >= unit_ticks) begin
                s_nxt.pre = '0;
                s_nxt.units = s_r.units - 8'h01;
                if (s_r.units == 8'h01) begin
                    s_nxt.running = 1'b0;
                    s_nxt.done = 1'b1;
                end
            end else begin
                s_nxt.pre = s_r.pre + UNIT_W'(1);
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign done = s_r.done;

endmodule // ivofh_delay_timer

// ---- hdl/ivofh_handler.sv ----
// Input over-voltage fault handler: threshold and reaction registers,
// fault detection and the response and retry sequencer.
// Assumes measured voltage, time unit, off command and clear come from
// logic on the same clock; the time unit comes from its own register.
// How it works
// - Sixteen-bit linear over-voltage threshold, host writable and readable.
// - Response 00 ignores the fault; output keeps running.
// - Response 01 runs on for the delay, then follows retry setting if still faulted.
// - Response 10 disables output at once, then follows retry setting.
// - Response 11 holds output off while fault lasts, resumes after.
// - Retry 000 makes no attempt; output off until fault cleared.
// - Retry 1 to 6 gives that many attempts, then latches off.
// - Attempt start to next attempt start is the programmed delay plus two clock cycles.
// - Retry 111 retries forever until commanded off or shut down.
// - Delay code n means 2 to the n time units.
// - One delay serves both run-on time and retry spacing.
// - Time unit length comes from a separate configuration input.
module ivofh_handler #(
    parameter int UNIT_W = 16
) (
    input wire logic clock,
    input wire logic rst_n,
    input ivofh_pkg::ivofh_req_type req,
    output ivofh_pkg::ivofh_ans_type ans,
    input wire logic [15:0] vin_meas,
    input wire logic [UNIT_W-1:0] time_unit_ticks,
    input wire logic cmd_off,
    input wire logic other_fault,
    input wire logic fault_clear,
    output logic output_enable,
    output logic fault_flag,
    output logic fault_latched,
    output logic retry_active
);
    import ivofh_pkg::*;

    typedef struct packed {
        ivofh_state_type state;
        logic [15:0] thr;
        ivofh_cfg_type cfg;
        logic [2:0] left;
        logic tstart;
        logic out_en;
        logic sticky;
        logic latched;
        logic retrying;
        ivofh_ans_type ans;
    } ivofh_main_state_type;

    ivofh_main_state_type s_r, s_nxt;
    logic fault_raw;
    logic tdone;

    // Fault is a level, one cycle behind the measurement
    ivofh_lin_cmp u_cmp (
        .clock(clock),
        .rst_n(rst_n),
        .value_a(vin_meas),
        .value_b(s_r.thr),
        .a_above_b(fault_raw)
    );

    // One timer for run-on and retry spacing alike
    ivofh_delay_timer #(
        .UNIT_W(UNIT_W)
    ) u_tmr (
        .clock(clock),
        .rst_n(rst_n),
        .start(s_r.tstart),
        .code(s_r.cfg.delay),
        .unit_ticks(time_unit_ticks),
        .done(tdone)
    );

    // Enter the retry phase: latch at once when no attempt is allowed
    function automatic ivofh_main_state_type ivofh_enter_retry(
        input ivofh_main_state_type st
    );
        ivofh_main_state_type r;
        r = st;
        if (st.cfg.retry == IVOFH_RETRY_NONE) begin
            r.state = IVOFH_LATCHED;
        end else begin
            r.state = IVOFH_RETRY_WAIT;
            r.left = st.cfg.retry;
            r.tstart = 1'b1;
        end
        return r;
    endfunction

    // Only the two register codes answer; anything else is refused
    function automatic logic ivofh_known_cmd(input logic [7:0] cmd);
        logic hit;
        hit = 1'b0;
        case (cmd)
            IVOFH_THRESHOLD_CMD: begin
                hit = 1'b1;
            end
            IVOFH_REACTION_CMD: begin
                hit = 1'b1;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
        return hit;
    endfunction

    // States in which the power stage may run
    function automatic logic ivofh_runs(input ivofh_state_type st);
        logic on;
        on = 1'b0;
        case (st)
            IVOFH_NORMAL: begin
                on = 1'b1;
            end
            IVOFH_DELAY: begin
                on = 1'b1; // Run-on keeps the output up
            end
            default: begin
                on = 1'b0;
            end
        endcase
        return on;
    endfunction

    // States still carrying out a response; off and other faults end them
    function automatic logic ivofh_pending(input ivofh_state_type st);
        logic p;
        p = 1'b0;
        case (st)
            IVOFH_DELAY: begin
                p = 1'b1;
            end
            IVOFH_RETRY_WAIT: begin
                p = 1'b1;
            end
            IVOFH_HOLD: begin
                p = 1'b1;
            end
            default: begin
                p = 1'b0;
            end
        endcase
        return p;
    endfunction

    always_comb begin
        s_nxt = s_r;
        // Strobes default low; a branch below raises them for one cycle
        s_nxt.tstart = 1'b0;
        s_nxt.ans.rvalid = 1'b0;
        s_nxt.ans.rerr = 1'b0;

        // Register writes; unknown codes only raise the error strobe
        if (req.wr) begin
            case (req.cmd)
                IVOFH_THRESHOLD_CMD: begin
                    s_nxt.thr = req.wdata;
                end
                IVOFH_REACTION_CMD: begin
                    s_nxt.cfg = req.wdata[7:0];
                end
                default: begin
                    s_nxt.cfg = s_r.cfg; // Unknown code writes nothing
                end
            endcase
        end

        // Register reads; upper byte of the reaction reads as zero
        if (req.rd) begin
            s_nxt.ans.rvalid = 1'b1;
            case (req.cmd)
                IVOFH_THRESHOLD_CMD: begin
                    s_nxt.ans.rdata = s_r.thr;
                end
                IVOFH_REACTION_CMD: begin
                    s_nxt.ans.rdata = {8'h00, s_r.cfg};
                end
                default: begin
                    s_nxt.ans.rdata = 16'h0000;
                end
            endcase
        end

        // Either strobe on an unknown code raises the error strobe
        if ((req.wr || req.rd) && !ivofh_known_cmd(req.cmd)) begin
            s_nxt.ans.rerr = 1'b1;
        end

        // Sticky fault flag; a fault in the clear cycle wins
        if (fault_clear) begin
            s_nxt.sticky = 1'b0;
        end
        if (fault_raw) begin
            s_nxt.sticky = 1'b1;
        end

        // Response sequencer
        case (s_r.state)
            IVOFH_NORMAL: begin
                // A unit commanded off has nothing to protect; no response starts
                if (fault_raw && !cmd_off) begin
                    case (s_r.cfg.rsp)
                        IVOFH_RSP_IGNORE: begin
                            s_nxt.state = IVOFH_NORMAL;
                        end
                        IVOFH_RSP_CONTINUE: begin
                            s_nxt.state = IVOFH_DELAY;
                            s_nxt.tstart = 1'b1;
                        end
                        IVOFH_RSP_DISABLE: begin
                            s_nxt = ivofh_enter_retry(s_nxt);
                        end
                        default: begin
                            s_nxt.state = IVOFH_HOLD;
                        end
                    endcase
                end
            end
            IVOFH_DELAY: begin
                // Output stays on; only the state at expiry matters
                if (tdone) begin
                    if (fault_raw) begin
                        s_nxt = ivofh_enter_retry(s_nxt);
                    end else begin
                        s_nxt.state = IVOFH_NORMAL;
                    end
                end
            end
            IVOFH_RETRY_WAIT: begin
                if (tdone) begin
                    // A clean input at expiry counts as a successful restart
                    if (!fault_raw) begin
                        s_nxt.state = IVOFH_NORMAL;
                    end else if (s_r.cfg.retry == IVOFH_RETRY_FOREVER) begin
                        s_nxt.tstart = 1'b1;
                    end else if (s_r.left <= 3'h1) begin
                        s_nxt.state = IVOFH_LATCHED;
                    end else begin
                        s_nxt.left = s_r.left - 3'h1;
                        s_nxt.tstart = 1'b1;
                    end
                end
            end
            IVOFH_HOLD: begin
                // Resuming uses no retry budget
                if (!fault_raw) begin
                    s_nxt.state = IVOFH_NORMAL;
                end
            end
            IVOFH_LATCHED: begin
                if (fault_clear) begin
                    s_nxt.state = IVOFH_NORMAL;
                end
            end
            default: begin
                s_nxt.state = IVOFH_NORMAL;
            end
        endcase

        // Off command drops any pending response; other faults latch it
        if (ivofh_pending(s_r.state)) begin
            if (other_fault) begin
                s_nxt.state = IVOFH_LATCHED;
                s_nxt.tstart = 1'b0;
            end else if (cmd_off) begin
                s_nxt.state = IVOFH_NORMAL;
                s_nxt.tstart = 1'b0;
            end
        end

        // Output on only in running states; external off overrides
        s_nxt.out_en = ivofh_runs(s_nxt.state) &&
                       !cmd_off && !other_fault;
        s_nxt.latched = s_nxt.state == IVOFH_LATCHED;
        s_nxt.retrying = s_nxt.state == IVOFH_RETRY_WAIT;
    end

    // Outputs come from this one register
    // Reset loads the default threshold and reaction
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s_r <= '0;
            s_r.state <= IVOFH_NORMAL;
            s_r.thr <= IVOFH_THRESHOLD_RST;
            s_r.cfg <= IVOFH_REACTION_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign ans = s_r.ans;
    assign output_enable = s_r.out_en;
    assign fault_flag = s_r.sticky;
    assign fault_latched = s_r.latched;
    assign retry_active = s_r.retrying;

endmodule // ivofh_handler

// ---- hdl/ivofh_lin_cmp.sv ----
// Registered greater-than compare of two values in linear numeric format.
// Assumes both inputs come from logic on the same clock.
module ivofh_lin_cmp (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [15:0] value_a,
    input wire logic [15:0] value_b,
    output logic a_above_b
);
    import ivofh_pkg::*;

    typedef struct packed {
        logic gt;
    } ivofh_cmp_state_type;

    ivofh_cmp_state_type s_r, s_nxt;

    // Scale mantissa by 2^(exp+16) so every exponent lands on one grid
    function automatic logic signed [47:0] ivofh_to_fixed(input logic [15:0] v);
        logic signed [47:0] m;
        logic [5:0] sh;
        m = 48'(signed'(v[10:0]));
        sh = 6'(signed'(v[15:11]) + 6'sd16);
        return m <<< sh;
    endfunction

    // Comparison is registered to keep the wide shifters off the fsm path
    always_comb begin
        s_nxt = s_r;
        s_nxt.gt = ivofh_to_fixed(value_a) > ivofh_to_fixed(value_b);
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign a_above_b = s_r.gt;

endmodule // ivofh_lin_cmp

// ---- hdl/ivofh_pkg.sv ----
// Shared constants and types for the input over-voltage fault handler.
// Assumes a decoded command port from a bus engine elsewhere in the device.
package ivofh_pkg;

    // Command codes of the two registers
    localparam logic [7:0] IVOFH_THRESHOLD_CMD = 8'h55;
    localparam logic [7:0] IVOFH_REACTION_CMD = 8'h56;

    // Reset values: largest positive linear value, and disable with no retry
    localparam logic [15:0] IVOFH_THRESHOLD_RST = 16'h7bff;
    localparam logic [7:0] IVOFH_REACTION_RST = 8'h80;

    // Response codes, bits 7:6 of the reaction register
    localparam logic [1:0] IVOFH_RSP_IGNORE = 2'h0;
    localparam logic [1:0] IVOFH_RSP_CONTINUE = 2'h1;
    localparam logic [1:0] IVOFH_RSP_DISABLE = 2'h2;
    localparam logic [1:0] IVOFH_RSP_HOLD = 2'h3;

    // Retry codes, bits 5:3 of the reaction register
    localparam logic [2:0] IVOFH_RETRY_NONE = 3'h0;
    localparam logic [2:0] IVOFH_RETRY_FOREVER = 3'h7;

    // Layout of the reaction register, msb first
    typedef struct packed {
        logic [1:0] rsp;
        logic [2:0] retry;
        logic [2:0] delay;
    } ivofh_cfg_type;

    // Decoded command request from the bus engine
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] cmd;
        logic [15:0] wdata;
    } ivofh_req_type;

    // Answer to a request
    typedef struct packed {
        logic rvalid;
        logic rerr;
        logic [15:0] rdata;
    } ivofh_ans_type;

    // Gray codes along normal, delay, retry wait, latched
    typedef enum logic [2:0] {
        IVOFH_NORMAL = 3'h0,
        IVOFH_DELAY = 3'h1,
        IVOFH_RETRY_WAIT = 3'h3,
        IVOFH_LATCHED = 3'h2,
        IVOFH_HOLD = 3'h6
    } ivofh_state_type;

endpackage

// ---- testbench/ivofh_host_model.sv ----
// Register host: one-cycle read and write strobes on the command port.
// Assumes inputs change at the falling clock edge.
module ivofh_host_model
    import ivofh_pkg::*;
(
    input wire logic clock,
    output ivofh_pkg::ivofh_req_type req,
    input ivofh_pkg::ivofh_ans_type ans
);
    initial req = '0;
    // Strobe stands one edge; answer stands the next cycle and is taken then
    task automatic access(input logic w, input logic [7:0] c, input logic [15:0] d,
                          output logic [15:0] q, output logic e);
        @(negedge clock);
        req = '{wr: w, rd: !w, cmd: c, wdata: d};
        @(negedge clock);
        q = ans.rdata;
        e = ans.rerr;
        req.wr = 1'b0;
        req.rd = 1'b0;
        req.wdata = ~d; // Released data must not look valid
    endtask
endmodule // ivofh_host_model

// ---- testbench/ivofh_properties.sv ----
// Port checks for the over-voltage fault handler.
// Assumes a bind into ivofh_handler; one clock, sync low reset.
module ivofh_properties
    import ivofh_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input ivofh_pkg::ivofh_req_type req,
    input ivofh_pkg::ivofh_ans_type ans,
    input wire logic cmd_off,
    input wire logic other_fault,
    input wire logic fault_clear,
    input wire logic output_enable,
    input wire logic fault_latched,
    input wire logic retry_active
);
    ivofh_cfg_type cfg_r;
    logic bad_cmd;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // Shadow of the reaction register, fed by the write strobe
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cfg_r <= IVOFH_REACTION_RST;
        end else if (req.wr && req.cmd == IVOFH_REACTION_CMD) begin
            cfg_r <= req.wdata[7:0];
        end
    end
    // Any code other than the two registers
    assign bad_cmd = req.cmd != IVOFH_THRESHOLD_CMD && req.cmd != IVOFH_REACTION_CMD;
    sequence s_clear_latched;
        fault_latched && fault_clear;
    endsequence
    sequence s_off_twice;
        cmd_off ##1 cmd_off;
    endsequence
    chk_read_answer: assert property (req.rd |=> ans.rvalid)
        else $error("read not answered");
    chk_bad_cmd: assert property ((req.rd || req.wr) && bad_cmd |=> ans.rerr)
        else $error("unknown command not refused");
    chk_ignore_runs: assert property (cfg_r.rsp == IVOFH_RSP_IGNORE && output_enable
        && !cmd_off && !other_fault |=> output_enable) else $error("ignore mode dropped output");
    chk_retry_off: assert property (retry_active |-> !output_enable)
        else $error("output on during retry wait");
    chk_latch_off: assert property (fault_latched |-> !output_enable)
        else $error("output on while latched");
    chk_latch_holds: assert property (fault_latched && !fault_clear |=> fault_latched)
        else $error("latch left without clear");
    chk_clear_exit: assert property (s_clear_latched |=> !fault_latched)
        else $error("clear did not leave latch");
    chk_retry_none: assert property ($rose(retry_active) |-> cfg_r.retry != 3'h0)
        else $error("retry wait with retries off");
    chk_off_stops: assert property (s_off_twice |-> !output_enable && !retry_active)
        else $error("off command ignored");
endmodule // ivofh_properties

// ---- testbench/tb.sv ----
// Self-checking bench for the over-voltage fault handler.
// Assumes the host model and the bound property checker.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import ivofh_pkg::*;
    localparam logic [15:0] THR = 16'h0064, LO = 16'h0032, HI = 16'h0078;
    logic clock = 1'b0, rst_n = 1'b0;
    ivofh_req_type req;
    ivofh_ans_type ans;
    logic [15:0] vin_meas = 16'h0032, rd;
    logic [3:0] time_unit_ticks = 4'h2;
    logic cmd_off = 1'b0, other_fault = 1'b0, fault_clear = 1'b0, er;
    logic output_enable, fault_flag, fault_latched, retry_active;
    int miscompares = 0, compares = 0;
    always #2.5 clock = ~clock;
    // Small unit width keeps delays short
    ivofh_handler #(.UNIT_W(4)) u_dut(.clock(clock), .rst_n(rst_n), .req(req), .ans(ans),
        .vin_meas(vin_meas), .time_unit_ticks(time_unit_ticks), .cmd_off(cmd_off),
        .other_fault(other_fault), .fault_clear(fault_clear), .output_enable(output_enable),
        .fault_flag(fault_flag), .fault_latched(fault_latched), .retry_active(retry_active));
    ivofh_host_model u_host(.clock(clock), .req(req), .ans(ans));
    task automatic test_done();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        u_host.access(1'b1, c, d, rd, er);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask
    // Bounded wait: 0 watches output_enable, 1 watches fault_latched
    task automatic wait_lvl(input int w, input logic v, input int lim, output int n);
        n = 0;
        while ((w == 0 ? output_enable : fault_latched) !== v) begin
            cyc(1);
            n++;
            if (n > lim) begin
                miscompares++;
                $display("BAD wait %0d exp %h seen %h", w, v, ~v);
                test_done();
            end
        end
    endtask
    // Input back in range, then clear the latch
    task automatic recover();
        vin_meas = LO;
        cyc(3);
        fault_clear = 1'b1;
        cyc(1);
        fault_clear = 1'b0;
        cyc(3);
        check("recover", 16'(output_enable), 16'h1);
    endtask
    task automatic t_regs();
        u_host.access(1'b0, IVOFH_THRESHOLD_CMD, 16'h0, rd, er);
        check("thr rst", rd, IVOFH_THRESHOLD_RST);
        wr(IVOFH_THRESHOLD_CMD, THR);
        wr(IVOFH_REACTION_CMD, 16'ha5c3);
        u_host.access(1'b0, IVOFH_THRESHOLD_CMD, 16'h0, rd, er);
        check("thr rb", rd, THR);
        u_host.access(1'b0, IVOFH_REACTION_CMD, 16'h0, rd, er);
        check("rsp rb", rd, 16'h00c3);
        u_host.access(1'b0, 8'h57, 16'h0, rd, er);
        check("bad rd", {er, rd[14:0]}, 16'h8000);
        $display("t_regs done");
    endtask
    task automatic t_ignore();
        wr(IVOFH_REACTION_CMD, 16'h0000);
        vin_meas = THR;
        cyc(6);
        check("at thr", 16'(fault_flag), 16'h0);
        vin_meas = THR + 16'h0001;
        cyc(20);
        check("ign flag", 16'(fault_flag), 16'h1);
        check("ign oe", 16'(output_enable), 16'h1);
        vin_meas = LO;
        $display("t_ignore done");
    endtask
    task automatic t_spacing();
        int n;
        for (int d = 0; d < 8; d++) begin
            wr(IVOFH_REACTION_CMD, {8'h00, 2'b10, 3'h1, 3'(d)});
            vin_meas = HI;
            wait_lvl(0, 1'b0, 8, n);
            check("off lat", 16'(n), 16'h2);
            vin_meas = LO;
            wait_lvl(0, 1'b1, 300, n);
            check("retry gap", 16'(n), 16'((2 << d) + 2));
        end
        $display("t_spacing done");
    endtask
    task automatic t_retries();
        int n;
        for (int r = 0; r < 7; r++) begin
            wr(IVOFH_REACTION_CMD, {8'h00, 2'b10, 3'(r), 3'h1});
            vin_meas = HI;
            wait_lvl(1, 1'b1, 80, n);
            check("latch time", 16'(n), 16'(2 + r * 6));
            recover();
        end
        $display("t_retries done");
    endtask
    task automatic t_forever();
        int n;
        time_unit_ticks = 4'h1;
        wr(IVOFH_REACTION_CMD, {8'h00, 2'b10, 3'h7, 3'h0});
        vin_meas = HI;
        cyc(200);
        check("fvr latch", 16'(fault_latched), 16'h0);
        check("fvr retry", 16'(retry_active), 16'h1);
        cmd_off = 1'b1;
        cyc(3);
        check("fvr off", 16'(retry_active), 16'h0);
        cmd_off = 1'b0;
        cyc(10);
        other_fault = 1'b1;
        wait_lvl(1, 1'b1, 8, n);
        other_fault = 1'b0;
        recover();
        $display("t_forever done");
    endtask
    task automatic t_cont_hold();
        int n;
        time_unit_ticks = 4'h2;
        wr(IVOFH_REACTION_CMD, {8'h00, 2'b01, 3'h0, 3'h2});
        vin_meas = HI;
        wait_lvl(0, 1'b0, 40, n);
        check("run on", 16'(n), 16'h000c);
        check("run latch", 16'(fault_latched), 16'h1);
        recover();
        wr(IVOFH_REACTION_CMD, {8'h00, 2'b11, 3'h0, 3'h0});
        vin_meas = HI;
        wait_lvl(0, 1'b0, 8, n);
        cyc(30);
        check("hold off", 16'(output_enable), 16'h0);
        vin_meas = LO;
        wait_lvl(0, 1'b1, 8, n);
        check("resume", 16'(n), 16'h2);
        $display("t_cont_hold done");
    endtask
    initial begin
        repeat (8) @(negedge clock);
        rst_n = 1'b1;
        t_regs();
        t_ignore();
        t_spacing();
        t_retries();
        t_forever();
        t_cont_hold();
        test_done();
    end
endmodule // tb
bind ivofh_handler ivofh_properties u_chk(.clock(clock), .rst_n(rst_n), .req(req),
    .ans(ans), .cmd_off(cmd_off), .other_fault(other_fault), .fault_clear(fault_clear),
    .output_enable(output_enable), .fault_latched(fault_latched),
    .retry_active(retry_active));
